/* File: hw/omc_top.sv */
// Operating mode controller: modes, active levels, data retention and identifier store.
// Assumes one 200 MHz clock, a power reset, and radio/discovery status from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
module omc_top
   import omc_pkg::*;
#(
   parameter longint ADV_TIMEOUT_CYC = OMC_ADV_TIMEOUT_CYC
)
(
   input wire logic core_clk_i, // Device clock.
   input wire logic rst_n_i, // Power reset, active low.
   input wire logic nvm_cfg_valid_i, // Configuration held in nonvolatile memory.
   input wire logic cmd_valid_i, // Command strobe.
   input wire omc_cmd_s cmd_i, // Command contents.
   input wire logic link_up_i, // Radio reports link formed.
   input wire logic link_lost_i, // Radio reports link lost.
   input wire logic disc_needed_i, // Pipe mapping is outdated or absent.
   input wire logic data_req_i, // Application data transfer request.
   output logic evt_valid_o, // Event strobe.
   output omc_evt_s evt_o, // Event contents.
   output omc_mode_e mode_o, // Current mode.
   output omc_level_e level_o, // Current active level.
   output logic radio_adv_o, // Radio advertising enable.
   output logic radio_drop_o, // Pulse: drop the link.
   output logic disc_start_o, // Pulse: start service discovery.
   output logic data_grant_o, // Application data permitted.
   output logic [1:0] test_fn_o, // Selected test function.
   output logic cfg_valid_o, // Configuration present.
   output logic cfg_locked_o, // Configuration locked.
   output logic dyn_valid_o, // Dynamic data held.
   input wire logic [OMC_IDX_W-1:0] id_rd_idx_i, // Base identifier read slot.
   input wire logic [OMC_SHORT_W-1:0] id_rd_short_i, // Short form to substitute.
   output logic [OMC_ID_W-1:0] id_rd_data_o // Expanded identifier.
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_s1_reg;
   logic rst_n_reg;

   // Two flops release the asynchronous reset in step with the clock.
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n_reg <= rst_s1_reg;
      end
   end

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   // Substitutes the short form into bytes 13 and 14 of a big-endian identifier.
   function automatic logic [OMC_ID_W-1:0] omc_expand(input logic [OMC_ID_W-1:0] base,
      input logic [OMC_SHORT_W-1:0] short_id);
      logic [OMC_ID_W-1:0] r;
      r = base;
      r[OMC_SHORT_MSB:OMC_SHORT_LSB] = short_id;
      return r;
   endfunction : omc_expand

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   logic started_reg;
   logic boot_reg;
   omc_mode_e mode_reg;
   omc_level_e level_reg;
   logic cfg_valid_reg;
   logic cfg_locked_reg;
   logic dyn_valid_reg;
   logic [1:0] test_fn_reg;
   logic cmd_ok;
   logic take;
   logic adv_expired;
   logic [63:0] adv_cnt_reg;

   assign take = cmd_valid_i && started_reg;
   assign adv_expired = (level_reg == OMC_LVL_ADVERT) && (adv_cnt_reg >= 64'(ADV_TIMEOUT_CYC - 1));

   // Decides whether a command applies to the present mode.
   always_comb
   begin
      cmd_ok = 1'b0;
      unique case (cmd_i.code)
         OMC_CMD_SLEEP: cmd_ok = (mode_reg == OMC_MODE_ACTIVE);
         OMC_CMD_WAKEUP: cmd_ok = (mode_reg == OMC_MODE_SLEEP);
         OMC_CMD_SETUP: cmd_ok = (mode_reg != OMC_MODE_SLEEP) && !cfg_locked_reg;
         OMC_CMD_TEST: cmd_ok = (mode_reg != OMC_MODE_SLEEP);
         OMC_CMD_CONNECT, OMC_CMD_BOND: cmd_ok = (mode_reg == OMC_MODE_ACTIVE) && (level_reg == OMC_LVL_STANDBY);
         OMC_CMD_DISCONNECT: cmd_ok = (mode_reg == OMC_MODE_ACTIVE) && (level_reg != OMC_LVL_STANDBY);
         OMC_CMD_SETUP_DATA, OMC_CMD_SETUP_DONE: cmd_ok = (mode_reg == OMC_MODE_SETUP) && !cfg_locked_reg;
         OMC_CMD_WRITE_ID: cmd_ok = (mode_reg == OMC_MODE_SETUP) && !cfg_locked_reg
            && (cmd_i.index < OMC_IDX_W'(OMC_NUM_BASE_IDS));
         OMC_CMD_TEST_SEL: cmd_ok = (mode_reg == OMC_MODE_TEST);
         default: cmd_ok = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Mode machine
   // ---------------------------------------------------------------
   // Selects the mode after reset and on host commands.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         mode_reg <= OMC_MODE_SETUP;
         boot_reg <= 1'b1;
      end
      else if (boot_reg)
      begin
         boot_reg <= 1'b0;
         mode_reg <= nvm_cfg_valid_i ? OMC_MODE_ACTIVE : OMC_MODE_SETUP;
      end
      else if (take && cmd_ok)
      begin
         unique case (cmd_i.code)
            OMC_CMD_SLEEP: mode_reg <= OMC_MODE_SLEEP;
            OMC_CMD_WAKEUP: mode_reg <= OMC_MODE_ACTIVE;
            OMC_CMD_SETUP: mode_reg <= OMC_MODE_SETUP;
            OMC_CMD_TEST: mode_reg <= (mode_reg == OMC_MODE_TEST) ? OMC_MODE_ACTIVE : OMC_MODE_TEST;
            OMC_CMD_SETUP_DONE: mode_reg <= OMC_MODE_ACTIVE;
            default: mode_reg <= mode_reg;
         endcase
      end
   end

   // Marks the device as started on the same edge that chooses the mode.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         started_reg <= 1'b0;
      else if (boot_reg)
         started_reg <= 1'b1;
   end

   // ---------------------------------------------------------------
   // Active levels
   // ---------------------------------------------------------------
   // Tracks standby, advertising and connected inside active mode.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         level_reg <= OMC_LVL_STANDBY;
      else if (mode_reg != OMC_MODE_ACTIVE)
         level_reg <= OMC_LVL_STANDBY;
      else if (take && cmd_ok && (cmd_i.code == OMC_CMD_SLEEP || cmd_i.code == OMC_CMD_SETUP
            || cmd_i.code == OMC_CMD_TEST || cmd_i.code == OMC_CMD_DISCONNECT))
         level_reg <= OMC_LVL_STANDBY;
      else
      begin
         unique case (level_reg)
            OMC_LVL_STANDBY:
               if (take && cmd_ok && (cmd_i.code == OMC_CMD_CONNECT || cmd_i.code == OMC_CMD_BOND))
                  level_reg <= OMC_LVL_ADVERT;
            OMC_LVL_ADVERT:
               if (link_up_i)
                  level_reg <= OMC_LVL_CONN;
               else if (adv_expired)
                  level_reg <= OMC_LVL_STANDBY;
            OMC_LVL_CONN:
               if (link_lost_i)
                  level_reg <= OMC_LVL_STANDBY;
            default: level_reg <= OMC_LVL_STANDBY;
         endcase
      end
   end

   // Counts advertising time; a formed link clears the count to zero.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         adv_cnt_reg <= 64'h0;
      else if (level_reg == OMC_LVL_ADVERT && !link_up_i)
         adv_cnt_reg <= adv_cnt_reg + 64'h1;
      else
         adv_cnt_reg <= 64'h0;
   end

   // ---------------------------------------------------------------
   // Configuration and dynamic data
   // ---------------------------------------------------------------
   // Holds configuration state; nonvolatile writes lock it.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         cfg_valid_reg <= 1'b0;
         cfg_locked_reg <= 1'b0;
      end
      else if (boot_reg && nvm_cfg_valid_i)
      begin
         cfg_valid_reg <= 1'b1;
         cfg_locked_reg <= 1'b1;
      end
      else if (take && cmd_ok && cmd_i.code == OMC_CMD_SETUP_DONE)
      begin
         cfg_valid_reg <= 1'b1;
         cfg_locked_reg <= cmd_i.nvm;
      end
   end

   // Dynamic data survives sleep; entering setup or test clears it.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         dyn_valid_reg <= 1'b0;
      else if (take && cmd_ok && (cmd_i.code == OMC_CMD_SETUP
            || (cmd_i.code == OMC_CMD_TEST && mode_reg != OMC_MODE_TEST)))
         dyn_valid_reg <= 1'b0;
      else if (level_reg == OMC_LVL_CONN && mode_reg == OMC_MODE_ACTIVE)
         dyn_valid_reg <= 1'b1;
   end

   // Selects the test function; leaving test mode clears it.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         test_fn_reg <= OMC_TEST_NONE;
      else if (mode_reg != OMC_MODE_TEST)
         test_fn_reg <= OMC_TEST_NONE;
      else if (take && cmd_ok && cmd_i.code == OMC_CMD_TEST_SEL
               && (cmd_i.test_sel == OMC_TEST_RADIO || cmd_i.test_sel == OMC_TEST_LOOP))
         test_fn_reg <= cmd_i.test_sel;
   end

   // ---------------------------------------------------------------
   // Base identifier store
   // ---------------------------------------------------------------
   logic [OMC_ID_W-1:0] base_id_reg [OMC_NUM_BASE_IDS];

   // Setup writes one of five base identifiers.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         for (int i = 0; i < OMC_NUM_BASE_IDS; i++)
            base_id_reg[i] <= '0;
      end
      else if (take && cmd_ok && cmd_i.code == OMC_CMD_WRITE_ID)
         base_id_reg[cmd_i.index] <= cmd_i.data;
   end

   // Registers the expanded identifier for the reader.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         id_rd_data_o <= '0;
      else if (id_rd_idx_i < OMC_IDX_W'(OMC_NUM_BASE_IDS))
         id_rd_data_o <= omc_expand(base_id_reg[id_rd_idx_i], id_rd_short_i);
      else
         id_rd_data_o <= '0;
   end

   // ---------------------------------------------------------------
   // Events and radio controls
   // ---------------------------------------------------------------
   logic leave_conn;
   assign leave_conn = (level_reg == OMC_LVL_CONN) && take && cmd_ok
                       && (cmd_i.code == OMC_CMD_SLEEP || cmd_i.code == OMC_CMD_SETUP
                           || cmd_i.code == OMC_CMD_TEST || cmd_i.code == OMC_CMD_DISCONNECT);

   // Issues one event per accepted or refused command; level events go out only in cycles with no command.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         evt_valid_o <= 1'b0;
         evt_o <= '{code: OMC_EVT_DONE, cmd: OMC_CMD_NONE};
      end
      else if (boot_reg)
      begin
         evt_valid_o <= 1'b1;
         evt_o <= '{code: OMC_EVT_STARTED, cmd: OMC_CMD_NONE};
      end
      else if (take)
      begin
         evt_valid_o <= 1'b1;
         evt_o <= '{code: cmd_ok ? OMC_EVT_DONE : OMC_EVT_ERROR, cmd: cmd_i.code};
      end
      else if (mode_reg == OMC_MODE_ACTIVE && level_reg == OMC_LVL_ADVERT && link_up_i)
      begin
         evt_valid_o <= 1'b1;
         evt_o <= '{code: OMC_EVT_CONNECTED, cmd: OMC_CMD_NONE};
      end
      else if (mode_reg == OMC_MODE_ACTIVE && adv_expired && !link_up_i)
      begin
         evt_valid_o <= 1'b1;
         evt_o <= '{code: OMC_EVT_ADV_TIMEOUT, cmd: OMC_CMD_NONE};
      end
      else if (mode_reg == OMC_MODE_ACTIVE && level_reg == OMC_LVL_CONN && link_lost_i)
      begin
         evt_valid_o <= 1'b1;
         evt_o <= '{code: OMC_EVT_DISCONNECTED, cmd: OMC_CMD_NONE};
      end
      else
         evt_valid_o <= 1'b0;
   end

   // Pulses the drop and discovery controls.
   always_ff @(posedge core_clk_i or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         radio_drop_o <= 1'b0;
         disc_start_o <= 1'b0;
      end
      else
      begin
         radio_drop_o <= leave_conn;
         disc_start_o <= (mode_reg == OMC_MODE_ACTIVE) && (level_reg == OMC_LVL_ADVERT)
                         && link_up_i && disc_needed_i;
      end
   end

   // Level outputs follow the state registers.
   assign mode_o = mode_reg;
   assign level_o = level_reg;
   assign radio_adv_o = (mode_reg == OMC_MODE_ACTIVE) && (level_reg == OMC_LVL_ADVERT);
   assign data_grant_o = cfg_valid_reg && (mode_reg == OMC_MODE_ACTIVE)
                         && (level_reg == OMC_LVL_CONN) && data_req_i;
   assign test_fn_o = test_fn_reg;
   assign cfg_valid_o = cfg_valid_reg;
   assign cfg_locked_o = cfg_locked_reg;
   assign dyn_valid_o = dyn_valid_reg;

endmodule : omc_top
`default_nettype wire

/* File: common/omc_pkg.sv */
// Constants, types and command codes for the operating mode controller.
// Assumes one device clock and a host that issues one system command at a time.
package omc_pkg;

   // ------------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      OMC_CMD_NONE = 4'h0,
      OMC_CMD_SLEEP = 4'h1,
      OMC_CMD_WAKEUP = 4'h2,
      OMC_CMD_SETUP = 4'h3,
      OMC_CMD_TEST = 4'h4,
      OMC_CMD_CONNECT = 4'h5,
      OMC_CMD_BOND = 4'h6,
      OMC_CMD_DISCONNECT = 4'h7,
      OMC_CMD_SETUP_DATA = 4'h8,
      OMC_CMD_SETUP_DONE = 4'h9,
      OMC_CMD_WRITE_ID = 4'hA,
      OMC_CMD_TEST_SEL = 4'hB
   } omc_cmd_e;

   // ------------------------------------------------------------------
   // Modes and active levels (one-hot)
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      OMC_MODE_SLEEP = 4'b0001,
      OMC_MODE_SETUP = 4'b0010,
      OMC_MODE_ACTIVE = 4'b0100,
      OMC_MODE_TEST = 4'b1000
   } omc_mode_e;

   typedef enum logic [2:0] {
      OMC_LVL_STANDBY = 3'b001,
      OMC_LVL_ADVERT = 3'b010,
      OMC_LVL_CONN = 3'b100
   } omc_level_e;

   // ------------------------------------------------------------------
   // Event codes
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      OMC_EVT_STARTED = 3'h1,
      OMC_EVT_DONE = 3'h2,
      OMC_EVT_ERROR = 3'h3,
      OMC_EVT_ADV_TIMEOUT = 3'h4,
      OMC_EVT_CONNECTED = 3'h5,
      OMC_EVT_DISCONNECTED = 3'h6
   } omc_evt_e;

   // ------------------------------------------------------------------
   // Sizes and constants
   // ------------------------------------------------------------------
   localparam int OMC_NUM_BASE_IDS = 5;
   localparam int OMC_ID_W = 128;
   localparam int OMC_SHORT_W = 16;
   localparam int OMC_SHORT_LSB = 8; // Byte 14 of a big-endian identifier.
   localparam int OMC_SHORT_MSB = 23; // Byte 13 of a big-endian identifier.
   localparam int OMC_IDX_W = 3;
   localparam logic [OMC_IDX_W-1:0] OMC_IDX_ZERO = 3'h0;
   localparam logic [1:0] OMC_TEST_NONE = 2'h0;
   localparam logic [1:0] OMC_TEST_RADIO = 2'h1;
   localparam logic [1:0] OMC_TEST_LOOP = 2'h2;
   localparam int OMC_ADV_TIMEOUT_S = 180;
   localparam int OMC_CLK_HZ = 200000000;
   localparam longint OMC_ADV_TIMEOUT_CYC = longint'(OMC_ADV_TIMEOUT_S) * longint'(OMC_CLK_HZ);

   // Command carrier.
   typedef struct packed {
      omc_cmd_e code;
      logic nvm; // Setup done targets nonvolatile memory.
      logic [OMC_IDX_W-1:0] index; // Base identifier slot.
      logic [1:0] test_sel; // Test function choice.
      logic [OMC_ID_W-1:0] data; // Identifier payload.
   } omc_cmd_s;

   // Event carrier.
   typedef struct packed {
      omc_evt_e code;
      omc_cmd_e cmd;
   } omc_evt_s;

endpackage : omc_pkg

/* File: testbench/omc_top_monitor.sv */
// Concurrent checks on the ports of the operating mode controller.
// Assumes it is bound into omc_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module omc_top_monitor
   import omc_pkg::*;
#(
   parameter longint ADV_TIMEOUT_CYC = 64'h14
)
(
   input wire logic core_clk_i, // Clock.
   input wire logic rst_n_i, // Reset, active low.
   input wire logic cmd_valid_i, // Command strobe.
   input wire omc_cmd_s cmd_i, // Command.
   input wire logic link_up_i, // Link formed.
   input wire logic disc_needed_i, // Discovery wanted.
   input wire logic evt_valid_o, // Event strobe.
   input wire omc_evt_s evt_o, // Event.
   input wire omc_mode_e mode_o, // Mode.
   input wire omc_level_e level_o, // Level.
   input wire logic radio_drop_o, // Link drop pulse.
   input wire logic disc_start_o, // Discovery pulse.
   input wire logic data_grant_o, // Data permitted.
   input wire logic cfg_valid_o, // Configuration held.
   input wire logic cfg_locked_o, // Configuration locked.
   input wire logic dyn_valid_o, // Dynamic data held.
   input wire logic [OMC_IDX_W-1:0] id_rd_idx_i, // Read slot.
   input wire logic [OMC_SHORT_W-1:0] id_rd_short_i, // Short form.
   input wire logic [OMC_ID_W-1:0] id_rd_data_o // Expanded identifier.
);
   logic started_reg;
   longint adv_cnt_reg;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Commands count only once the started notice has been seen.
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i) started_reg <= 1'b0;
      else if (evt_valid_o && evt_o.code == OMC_EVT_STARTED) started_reg <= 1'b1;
   // Cycles spent advertising, so an endless advert is caught.
   always_ff @(posedge core_clk_i or negedge rst_n_i)
      if (!rst_n_i) adv_cnt_reg <= 64'h0;
      else if (mode_o == OMC_MODE_ACTIVE && level_o == OMC_LVL_ADVERT) adv_cnt_reg <= adv_cnt_reg + 64'h1;
      else adv_cnt_reg <= 64'h0;
   sequence s_cmd(omc_cmd_e c);
      started_reg && cmd_valid_i && cmd_i.code == c;
   endsequence
   evt_answer_a: assert property (started_reg && cmd_valid_i |=> evt_valid_o && evt_o.cmd == $past(cmd_i.code))
      else $error("command not answered");
   sleep_entry_a: assert property (s_cmd(OMC_CMD_SLEEP) ##0 mode_o == OMC_MODE_ACTIVE
      |=> mode_o == OMC_MODE_SLEEP && evt_o.code == OMC_EVT_DONE) else $error("sleep not entered");
   wake_standby_a: assert property (s_cmd(OMC_CMD_WAKEUP) ##0 mode_o == OMC_MODE_SLEEP
      |=> mode_o == OMC_MODE_ACTIVE && level_o == OMC_LVL_STANDBY) else $error("wakeup not to standby");
   bad_mode_a: assert property (s_cmd(OMC_CMD_SLEEP) ##0 mode_o != OMC_MODE_ACTIVE
      |=> evt_o.code == OMC_EVT_ERROR && $stable(mode_o) && $stable(dyn_valid_o)) else $error("bad command acted");
   test_clear_a: assert property (s_cmd(OMC_CMD_TEST) ##0 mode_o inside {OMC_MODE_ACTIVE, OMC_MODE_SETUP}
      |=> mode_o == OMC_MODE_TEST && !dyn_valid_o) else $error("test entry kept data");
   drop_link_a: assert property (s_cmd(OMC_CMD_SLEEP) ##0 level_o == OMC_LVL_CONN && mode_o == OMC_MODE_ACTIVE
      |=> ##[0:1] radio_drop_o) else $error("link not dropped");
   link_conn_a: assert property (started_reg && link_up_i && mode_o == OMC_MODE_ACTIVE && level_o == OMC_LVL_ADVERT
      |=> level_o == OMC_LVL_CONN && disc_start_o == $past(disc_needed_i)) else $error("link not connected");
   adv_limit_a: assert property (adv_cnt_reg <= ADV_TIMEOUT_CYC + 64'h1)
      else $error("advertising outlived timeout");
   grant_gate_a: assert property (data_grant_o |-> mode_o == OMC_MODE_ACTIVE && level_o == OMC_LVL_CONN && cfg_valid_o)
      else $error("data granted too early");
   cfg_lock_a: assert property (s_cmd(OMC_CMD_SETUP) ##0 cfg_locked_o |=> evt_o.code == OMC_EVT_ERROR && cfg_locked_o)
      else $error("locked setup reopened");
   id_expand_a: assert property (started_reg && id_rd_idx_i < 3'h5 |=> id_rd_data_o[23:8] == $past(id_rd_short_i))
      else $error("short form not substituted");
endmodule : omc_top_monitor
`default_nettype wire

/* File: testbench/omc_host_model.sv */
// Host processor model: issues one command at a time and collects the answer.
// Assumes it shares the device clock and acts on falling edges.
`timescale 1ns/1ps
`default_nettype none
module omc_host_model
   import omc_pkg::*;
(
   input wire logic clk_i, // Clock.
   input wire logic rst_n_i, // Reset, active low.
   input wire logic evt_valid_i, // Event strobe.
   input wire omc_evt_s evt_i, // Event.
   output logic cmd_valid_o, // Command strobe.
   output omc_cmd_s cmd_o // Command.
);
   logic started;
   initial cmd_valid_o = 1'b0;
   initial cmd_o = '0;
   // Remembers the started notice; send itself does not wait for it.
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i) started <= 1'b0;
      else if (evt_valid_i && evt_i.code == OMC_EVT_STARTED) started <= 1'b1;
   // Waits a bounded time for the started notice.
   task automatic wait_started;
      for (int i = 0; i < 40 && !started; i++) @(negedge clk_i);
   endtask : wait_started
   // One command, then three cycles to catch its first event before returning.
   task automatic send(input omc_cmd_e c, input logic nvm, input logic [2:0] idx, input logic [1:0] ts,
                       input logic [127:0] d, output omc_evt_e rc);
      rc = omc_evt_e'(3'h0);
      @(negedge clk_i);
      cmd_o = '{code: c, nvm: nvm, index: idx, test_sel: ts, data: d};
      cmd_valid_o = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         @(negedge clk_i);
         cmd_valid_o = 1'b0;
         cmd_o = ~cmd_o; // Released fields do not keep the old value.
         if (evt_valid_i === 1'b1 && rc == 3'h0) rc = evt_i.code;
      end
   endtask : send
endmodule : omc_host_model
`default_nettype wire

/* File: testbench/omc_top_tb.sv */
// Self-checking bench for the operating mode controller.
// Assumes the host model drives commands and the bench drives radio status.
`timescale 1ns/1ps
`default_nettype none
module omc_top_tb;
   import omc_pkg::*;
   logic core_clk_i, rst_n_i, nvm_cfg_valid_i, link_up_i, link_lost_i, disc_needed_i, data_req_i;
   logic cmd_valid_i, evt_valid_o, radio_adv_o, radio_drop_o, disc_start_o, data_grant_o;
   logic cfg_valid_o, cfg_locked_o, dyn_valid_o;
   omc_cmd_s cmd_i;
   omc_evt_s evt_o;
   omc_mode_e mode_o;
   omc_level_e level_o;
   logic [1:0] test_fn_o;
   logic [2:0] id_rd_idx_i;
   logic [15:0] id_rd_short_i;
   logic [127:0] id_rd_data_o;
   int n_errors = 0, total_checks = 0, n_disc = 0, n_drop = 0;
   omc_evt_e rc;
   localparam logic [127:0] ID0 = 128'h00112233445566778899AABBCCDDEEFF;
   omc_top #(.ADV_TIMEOUT_CYC(64'h14)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .nvm_cfg_valid_i(nvm_cfg_valid_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .link_up_i(link_up_i),
      .link_lost_i(link_lost_i), .disc_needed_i(disc_needed_i), .data_req_i(data_req_i),
      .evt_valid_o(evt_valid_o), .evt_o(evt_o), .mode_o(mode_o), .level_o(level_o), .radio_adv_o(radio_adv_o),
      .radio_drop_o(radio_drop_o), .disc_start_o(disc_start_o), .data_grant_o(data_grant_o),
      .test_fn_o(test_fn_o), .cfg_valid_o(cfg_valid_o), .cfg_locked_o(cfg_locked_o), .dyn_valid_o(dyn_valid_o),
      .id_rd_idx_i(id_rd_idx_i), .id_rd_short_i(id_rd_short_i), .id_rd_data_o(id_rd_data_o));
   omc_host_model i_host (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .evt_valid_i(evt_valid_o), .evt_i(evt_o),
      .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
   // Clock at 200 MHz.
   initial
   begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   // Counts the one-cycle discovery and drop pulses.
   always @(posedge core_clk_i)
   begin
      if (disc_start_o === 1'b1) n_disc++;
      if (radio_drop_o === 1'b1) n_drop++;
   end
   task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("Errors %0d, checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   task automatic do_reset(input logic nvm);
      @(negedge core_clk_i);
      rst_n_i = 1'b0;
      nvm_cfg_valid_i = nvm;
      repeat (12) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      i_host.wait_started();
      chk("started", 1'b1, i_host.started);
   endtask : do_reset
   task automatic cmd(input omc_cmd_e c, input omc_evt_e exp, input logic [1:0] ts = 2'h0,
                      input logic [2:0] idx = 3'h0, input logic nvm = 1'b0);
      i_host.send(c, nvm, idx, ts, ID0 ^ {125'h0, idx}, rc);
      chk(c.name(), exp, rc);
   endtask : cmd
   task automatic pulse(input logic up, input logic need);
      @(negedge core_clk_i);
      link_up_i = up;
      link_lost_i = !up;
      disc_needed_i = need;
      @(negedge core_clk_i);
      link_up_i = 1'b0;
      link_lost_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
   endtask : pulse
   task automatic t_boot;
      do_reset(1'b0);
      chk("mode", OMC_MODE_SETUP, mode_o);
      chk("cfg", 1'b0, cfg_valid_o);
      cmd(OMC_CMD_SLEEP, OMC_EVT_ERROR);
      chk("mode", OMC_MODE_SETUP, mode_o);
   endtask : t_boot
   task automatic t_setup;
      cmd(OMC_CMD_WRITE_ID, OMC_EVT_DONE, 2'h0, 3'h0);
      cmd(OMC_CMD_WRITE_ID, OMC_EVT_DONE, 2'h0, 3'h4);
      cmd(OMC_CMD_WRITE_ID, OMC_EVT_ERROR, 2'h0, 3'h5);
      for (int i = 0; i < 5; i += 4)
      begin
         @(negedge core_clk_i);
         id_rd_idx_i = 3'(i);
         id_rd_short_i = 16'hABCD ^ 16'(i);
         @(negedge core_clk_i);
         chk("id", {ID0[127:24], 16'hABCD ^ 16'(i), ID0[7:0] ^ 8'(i)}, id_rd_data_o);
      end
      id_rd_idx_i = 3'h7;
      cmd(OMC_CMD_SETUP_DATA, OMC_EVT_DONE);
      cmd(OMC_CMD_SETUP_DONE, OMC_EVT_DONE);
      chk("mode", {OMC_MODE_ACTIVE, OMC_LVL_STANDBY, 2'h2}, {mode_o, level_o, cfg_valid_o, cfg_locked_o});
   endtask : t_setup
   task automatic t_link;
      data_req_i = 1'b1;
      @(negedge core_clk_i);
      chk("grant", 1'b0, data_grant_o);
      cmd(OMC_CMD_CONNECT, OMC_EVT_DONE);
      chk("advert", {OMC_LVL_ADVERT, 1'b1}, {level_o, radio_adv_o});
      pulse(1'b1, 1'b1);
      chk("conn", {OMC_LVL_CONN, 1'b1, 1'b1}, {level_o, data_grant_o, dyn_valid_o});
      chk("disc", 1, n_disc);
      repeat (30) @(negedge core_clk_i);
      chk("conn", OMC_LVL_CONN, level_o);
      pulse(1'b0, 1'b0);
      chk("lost", OMC_LVL_STANDBY, level_o);
      cmd(OMC_CMD_BOND, OMC_EVT_DONE);
      repeat (30) @(negedge core_clk_i);
      chk("timeout", {OMC_LVL_STANDBY, OMC_EVT_ADV_TIMEOUT}, {level_o, evt_o.code});
      cmd(OMC_CMD_CONNECT, OMC_EVT_DONE);
      pulse(1'b1, 1'b0);
      chk("disc", 1, n_disc);
      cmd(OMC_CMD_DISCONNECT, OMC_EVT_DONE);
      repeat (2) @(negedge core_clk_i);
      chk("drop", {OMC_LVL_STANDBY, 32'd1}, {level_o, n_drop});
   endtask : t_link
   task automatic t_sleep;
      cmd(OMC_CMD_CONNECT, OMC_EVT_DONE);
      pulse(1'b1, 1'b0);
      cmd(OMC_CMD_SLEEP, OMC_EVT_DONE);
      repeat (2) @(negedge core_clk_i);
      chk("drop", 2, n_drop);
      chk("sleep", {OMC_MODE_SLEEP, 2'h3}, {mode_o, dyn_valid_o, cfg_valid_o});
      cmd(OMC_CMD_CONNECT, OMC_EVT_ERROR);
      cmd(OMC_CMD_WAKEUP, OMC_EVT_DONE);
      chk("wake", {OMC_MODE_ACTIVE, OMC_LVL_STANDBY, 1'b1}, {mode_o, level_o, dyn_valid_o});
   endtask : t_sleep
   task automatic t_test;
      cmd(OMC_CMD_TEST, OMC_EVT_DONE);
      chk("test", {OMC_MODE_TEST, 1'b0}, {mode_o, dyn_valid_o});
      for (int t = 1; t < 3; t++)
      begin
         cmd(OMC_CMD_TEST_SEL, OMC_EVT_DONE, 2'(t));
         chk("testfn", t, test_fn_o);
      end
      cmd(OMC_CMD_CONNECT, OMC_EVT_ERROR);
      cmd(OMC_CMD_TEST, OMC_EVT_DONE);
      cmd(OMC_CMD_SETUP, OMC_EVT_DONE);
      chk("mode", OMC_MODE_SETUP, mode_o);
      cmd(OMC_CMD_SETUP_DONE, OMC_EVT_DONE, 2'h0, 3'h0, 1'b1);
      chk("lock", 1'b1, cfg_locked_o);
      cmd(OMC_CMD_SETUP, OMC_EVT_ERROR);
   endtask : t_test
   task automatic t_reset;
      do_reset(1'b1);
      chk("boot", {OMC_MODE_ACTIVE, OMC_LVL_STANDBY, 1'b0}, {mode_o, level_o, dyn_valid_o});
      do_reset(1'b0);
      chk("boot", {OMC_MODE_SETUP, 1'b0}, {mode_o, cfg_valid_o});
   endtask : t_reset
   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      $display("MISMATCH watchdog expected end seen timeout");
      stop_test();
   end
   // Main sequence.
   initial
   begin
      {rst_n_i, nvm_cfg_valid_i, link_up_i, link_lost_i, disc_needed_i, data_req_i} = 6'h0;
      id_rd_idx_i = 3'h7;
      id_rd_short_i = 16'h0;
      t_boot();
      t_setup();
      t_link();
      t_sleep();
      t_test();
      t_reset();
      stop_test();
   end
endmodule : omc_top_tb
bind omc_top omc_top_monitor #(.ADV_TIMEOUT_CYC(ADV_TIMEOUT_CYC)) i_mon (.*);
`default_nettype wire
